// file: common/vfe_pkg.sv
// constants and types for the vector fp exception unit
package vfe_pkg;
   // ----------------------------------------------------------------
   // exception vector bit positions
   // ----------------------------------------------------------------
   localparam int EXC_W = 6;
   localparam logic [5:0] EXC_E = 6'h20; // unimplemented operation
   localparam logic [5:0] EXC_V = 6'h10; // invalid operation
   localparam logic [5:0] EXC_Z = 6'h08; // divide by zero
   localparam logic [5:0] EXC_O = 6'h04; // overflow
   localparam logic [5:0] EXC_U = 6'h02; // underflow
   localparam logic [5:0] EXC_I = 6'h01; // inexact
   // ----------------------------------------------------------------
   // default nan encodings, right aligned in a 64-bit lane
   // ----------------------------------------------------------------
   localparam logic [63:0] QNAN_H = 64'h0000_0000_0000_7e00;
   localparam logic [63:0] QNAN_W = 64'h0000_0000_7fc0_0000;
   localparam logic [63:0] QNAN_D = 64'h7ff8_0000_0000_0000;
   localparam logic [63:0] SNAN_H = 64'h0000_0000_0000_7c00;
   localparam logic [63:0] SNAN_W = 64'h0000_0000_7f80_0000;
   localparam logic [63:0] SNAN_D = 64'h7ff0_0000_0000_0000;
   // ----------------------------------------------------------------
   // vector geometry and trap reporting
   // ----------------------------------------------------------------
   localparam int VEC_W = 128;
   localparam int LANES = 8; // most elements processed per cycle (16-bit)
   localparam logic [4:0] EXC_CODE_FPE = 5'h0e;
   localparam logic [5:0] CAUSE_RST = 6'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   // element formats
   typedef enum logic [1:0] {
      FMT_H = 2'b01,
      FMT_W = 2'b10,
      FMT_D = 2'b11
   } vfe_fmt_t;
   // end-of-instruction sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DONE = 2'b10
   } vfe_state_t;
endpackage

// file: rtl/vfe_unit.sv
// per-element fp exception handling for a 128-bit vector unit
// Function
// - default quiet nan per element width
// - signaling nan carries nonzero reason byte
// - unimplemented operation always enabled
// - disabled overflow also sets inexact
// - exact disabled underflow is dropped
// - no exception: write result, cause unchanged
// - disabled exceptions: accumulate, write default
// - enabled, trapping: accumulate, no write
// - enabled, non-trapping: write coded signaling nan
// - no enabled cause: merge cause into flags
// - enabled cause: trap, flags untouched
// - single nan operand payload propagates
// - multiple nans: leftmost chosen
// - signaling nan raises invalid, wins
// - quieting keeps sign and payload, sets top mantissa bit
// - flush tiny results, subnormal inputs to zero
// - flushed result raises inexact and underflow except reciprocal approximations
// - flushed input raises inexact except compares
// - never flush half or non-arithmetic inputs
// - tiny-before-rounding results also flushed
// - other exceptions use flushed values
// - cause cleared at instruction start
// - non-trapping mode never traps
// - trap reported with code 0x0e
`timescale 1ns/10ps
module vfe_unit
   import vfe_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control and status
   input wire logic [5:0] enableMask,
   input wire logic nonTrappingMode,
   input wire logic flushToZeroControl,
   output logic [5:0] causeField,
   output logic [5:0] flagsField,
   // instruction framing from the datapath
   input wire logic instStart,
   input wire logic instLast,
   input wire logic [1:0] elemFormat,
   input wire logic isCompare,
   input wire logic isRecipApprox,
   input wire logic isArith,
   input wire logic nanPropagate,
   // per-element datapath inputs, one 64-bit lane slot per element
   input wire logic [LANES-1:0] elemValid,
   input wire logic [LANES*6-1:0] rawExc,
   input wire logic [LANES-1:0] tinyResult,
   input wire logic [LANES*3-1:0] subnormIn,
   input wire logic [LANES*3-1:0] snanIn,
   input wire logic [LANES*3-1:0] qnanIn,
   input wire logic [LANES*64*3-1:0] operands,
   input wire logic [LANES*64-1:0] resultIn,
   input wire logic [LANES*64-1:0] defaultIn,
   // per-element write-back
   output logic [LANES*64-1:0] destValue,
   output logic [LANES-1:0] destWrite,
   // trap to processor exception logic
   output logic vecFpException,
   output logic [4:0] exceptionCodeField,
   output logic [5:0] trapCause
);
   // ----------------------------------------------------------------
   // per-element combinational evaluation
   // ----------------------------------------------------------------
   logic [5:0] enEff; // effective enable mask
   logic [LANES*6-1:0] causeAdd; // bits each element ors into cause
   logic [LANES*64-1:0] valNxt;
   logic [LANES-1:0] wrNxt;
   logic [5:0] causeOr;
   logic flushOk; // flushing allowed for this instruction

   assign enEff = enableMask | EXC_E;
   assign flushOk = flushToZeroControl && isArith && (elemFormat != FMT_H);

   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : gElem
         logic [5:0] c;
         logic [63:0] r;
         logic [63:0] d;
         logic [63:0] snan;
         logic [63:0] qnan;
         logic [63:0] nanSel;
         logic [63:0] qSel;
         logic [63:0] signOnly;
         logic [63:0] op [3];
         logic haveNan;
         int k;
         always_comb
         begin
            c = rawExc[g*6 +: 6];
            r = resultIn[g*64 +: 64];
            d = defaultIn[g*64 +: 64];
            nanSel = '0;
            haveNan = 1'b0;
            for (k = 0; k < 3; k++)
            begin
               op[k] = operands[(g*3+k)*64 +: 64];
            end
            // per format constants and sign bit of the result
            case (elemFormat)
               FMT_H:
               begin
                  snan = SNAN_H;
                  qnan = QNAN_H;
                  signOnly = {48'h0, r[15], 15'h0};
               end
               FMT_W:
               begin
                  snan = SNAN_W;
                  qnan = QNAN_W;
                  signOnly = {32'h0, r[31], 31'h0};
               end
               default:
               begin
                  snan = SNAN_D;
                  qnan = QNAN_D;
                  signOnly = {r[63], 63'h0};
               end
            endcase
            // leftmost signaling nan first, else leftmost quiet nan
            for (k = 2; k >= 0; k--)
            begin
               if (qnanIn[g*3+k])
               begin
                  nanSel = op[k];
                  haveNan = 1'b1;
               end
            end
            for (k = 2; k >= 0; k--)
            begin
               if (snanIn[g*3+k])
               begin
                  nanSel = op[k];
                  haveNan = 1'b1;
               end
            end
            if (|snanIn[g*3 +: 3])
            begin
               c = c | EXC_V;
            end
            // quieting sets the top mantissa bit, keeps sign and payload
            qSel = nanSel | qnan;
            if (nanPropagate && haveNan)
            begin
               r = qSel;
               d = qSel;
            end
            // flush handling: clears unimplemented, flushes tiny results, raises inexact and underflow
            if (flushOk)
            begin
               c = c & ~EXC_E;
               if (|subnormIn[g*3 +: 3] && !isCompare)
               begin
                  c = c | EXC_I;
               end
               if (tinyResult[g])
               begin
                  r = signOnly;
                  d = signOnly;
                  if (!isRecipApprox)
                  begin
                     c = c | EXC_U | EXC_I;
                  end
               end
            end
            else if (tinyResult[g] || |subnormIn[g*3 +: 3])
            begin
               c = c | EXC_E;
            end
            // disabled overflow implies inexact
            if ((c & EXC_O) != 6'h00 && (enEff & EXC_O) == 6'h00)
            begin
               c = c | EXC_I;
            end
            // exact disabled underflow is suppressed
            if ((c & EXC_U) != 6'h00 && (enEff & EXC_U) == 6'h00 && (c & EXC_I) == 6'h00)
            begin
               c = c & ~EXC_U;
            end
            // destination and cause selection
            if (!elemValid[g])
            begin
               causeAdd[g*6 +: 6] = 6'h00;
               valNxt[g*64 +: 64] = '0;
               wrNxt[g] = 1'b0;
            end
            else if ((c & enEff) == 6'h00)
            begin
               causeAdd[g*6 +: 6] = c;
               valNxt[g*64 +: 64] = (c == 6'h00) ? r : d;
               wrNxt[g] = 1'b1;
            end
            else if (!nonTrappingMode)
            begin
               causeAdd[g*6 +: 6] = c;
               valNxt[g*64 +: 64] = '0;
               wrNxt[g] = 1'b0;
            end
            else
            begin
               causeAdd[g*6 +: 6] = 6'h00;
               valNxt[g*64 +: 64] = snan | {58'h0, c};
               wrNxt[g] = 1'b1;
            end
         end
      end
   endgenerate

   // or of all element contributions this cycle
   always_comb
   begin
      causeOr = 6'h00;
      for (int j = 0; j < LANES; j++)
      begin
         causeOr = causeOr | causeAdd[j*6 +: 6];
      end
   end

   // ----------------------------------------------------------------
   // cause, flags and trap sequencing
   // ----------------------------------------------------------------
   vfe_state_t state_r, state_nxt;
   logic [5:0] cause_r, cause_nxt;
   logic [5:0] flags_r, flags_nxt;
   logic trap_r, trap_nxt;
   logic [5:0] trapCause_r, trapCause_nxt;
   logic [LANES*64-1:0] dest_r;
   logic [LANES-1:0] destWr_r;
   logic [5:0] causeAcc; // cause after this cycle's elements

   // next-state computation
   always_comb
   begin
      state_nxt = state_r;
      cause_nxt = cause_r;
      flags_nxt = flags_r;
      trap_nxt = 1'b0;
      trapCause_nxt = trapCause_r;
      causeAcc = (instStart ? CAUSE_RST : cause_r) | causeOr;
      case (state_r)
         ST_IDLE, ST_DONE:
         begin
            state_nxt = ST_IDLE;
            if (instStart)
            begin
               cause_nxt = causeAcc;
               state_nxt = instLast ? ST_DONE : ST_BUSY;
            end
         end
         ST_BUSY:
         begin
            cause_nxt = causeAcc;
            if (instLast)
            begin
               state_nxt = ST_DONE;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
      // end of instruction: trap or merge flags
      if ((instStart || state_r == ST_BUSY) && instLast)
      begin
         if ((causeAcc & enEff) == 6'h00 || nonTrappingMode)
         begin
            flags_nxt = flags_r | causeAcc;
         end
         else
         begin
            trap_nxt = 1'b1;
            trapCause_nxt = causeAcc;
         end
      end
   end

   // state registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_r <= ST_IDLE;
         cause_r <= CAUSE_RST;
         flags_r <= FLAGS_RST;
         trap_r <= 1'b0;
         trapCause_r <= CAUSE_RST;
         dest_r <= '0;
         destWr_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cause_r <= cause_nxt;
         flags_r <= flags_nxt;
         trap_r <= trap_nxt;
         trapCause_r <= trapCause_nxt;
         dest_r <= valNxt;
         destWr_r <= wrNxt & {LANES{instStart || state_r == ST_BUSY}};
      end
   end

   // registered outputs, exception code is a constant
   assign causeField = cause_r;
   assign flagsField = flags_r;
   assign destValue = dest_r;
   assign destWrite = destWr_r;
   assign vecFpException = trap_r;
   assign exceptionCodeField = EXC_CODE_FPE;
   assign trapCause = trapCause_r;
endmodule // vfe_unit

// file: tb/vfe_checker.sv
// port-level assertions for the vector fp exception unit
`timescale 1ns/10ps
module vfe_checker
   import vfe_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control and element inputs
   input wire logic [5:0] enableMask,
   input wire logic nonTrappingMode,
   input wire logic instStart,
   input wire logic instLast,
   input wire logic [LANES*6-1:0] rawExc,
   input wire logic [LANES-1:0] tinyResult,
   input wire logic [LANES*3-1:0] subnormIn,
   input wire logic [LANES*3-1:0] snanIn,
   // status and trap
   input wire logic [5:0] causeField,
   input wire logic [5:0] flagsField,
   input wire logic vecFpException,
   input wire logic [4:0] exceptionCodeField,
   input wire logic [5:0] trapCause
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   chk_code_fixed: assert property (exceptionCodeField == EXC_CODE_FPE)
      else $error("trap code wrong");
   chk_ovf_sets_inexact: assert property (instStart && instLast && rawExc == EXC_O
      && !enableMask[2] && !enableMask[0] && tinyResult == 0 && subnormIn == 0 && snanIn == 0
      |=> causeField == 6'h05) else $error("overflow cause wrong");
   chk_cause_starts_clear: assert property (instStart && rawExc == 0
      && tinyResult == 0 && subnormIn == 0 && snanIn == 0 |=> causeField == 6'h00)
      else $error("cause not cleared");
   chk_trap_after_last: assert property (vecFpException |-> $past(instLast))
      else $error("trap without last group");
   chk_nontrap_no_trap: assert property ($past(instLast) && $past(nonTrappingMode)
      |-> !vecFpException) else $error("trap in non-trapping mode");
   chk_flags_merge: assert property ($past(instLast) && !vecFpException
      |-> flagsField == ($past(flagsField) | causeField)) else $error("flags not merged");
   chk_trap_keeps_flags: assert property (vecFpException |-> $stable(flagsField))
      else $error("flags changed on trap");
   chk_trap_enabled: assert property (vecFpException
      |-> (trapCause & ($past(enableMask) | EXC_E)) != 6'h00) else $error("trap not enabled");
endmodule // vfe_checker
bind vfe_unit vfe_checker u_chk (.mclk, .srst, .enableMask, .nonTrappingMode, .instStart,
   .instLast, .rawExc, .tinyResult, .subnormIn, .snanIn, .causeField, .flagsField,
   .vecFpException, .exceptionCodeField, .trapCause);

// file: tb/vfe_datapath_model.sv
// datapath stand-in placing one element in slot 0 of the lane buses
`timescale 1ns/10ps
module vfe_datapath_model
   import vfe_pkg::*;
#(
   parameter logic [63:0] RES_VAL = 64'h0000_0000_3f80_0000,
   parameter logic [63:0] DEF_VAL = 64'h0000_0000_7f80_0000
)
(
   // conditions of the element
   input wire logic [5:0] exc,
   input wire logic tny,
   input wire logic sub,
   input wire logic [2:0] sn, // operand is a signaling nan, operand 0 in bit 0
   input wire logic [2:0] qn, // operand is a quiet nan
   input wire logic [191:0] ops, // operand values, operand 0 in the low word
   // lane buses toward the unit
   output logic [LANES-1:0] elemValid,
   output logic [LANES*6-1:0] rawExc,
   output logic [LANES-1:0] tinyResult,
   output logic [LANES*3-1:0] subnormIn,
   output logic [LANES*3-1:0] snanIn,
   output logic [LANES*3-1:0] qnanIn,
   output logic [LANES*64*3-1:0] operands,
   output logic [LANES*64-1:0] resultIn,
   output logic [LANES*64-1:0] defaultIn
);
   // slot 0 carries the element, other slots stay idle
   assign elemValid = 8'h01;
   assign rawExc = {42'h0, exc};
   assign tinyResult = {7'h0, tny};
   assign subnormIn = {23'h0, sub};
   assign snanIn = {21'h0, sn};
   assign qnanIn = {21'h0, qn};
   assign operands = {{(LANES-1)*192{1'b0}}, ops};
   assign resultIn = {{(LANES-1)*64{1'b0}}, RES_VAL};
   assign defaultIn = {{(LANES-1)*64{1'b0}}, DEF_VAL};
endmodule // vfe_datapath_model

// file: tb/test_vfe_unit.sv
// self-checking bench for the vector fp exception unit
`timescale 1ns/10ps
module test_vfe_unit;
   import vfe_pkg::*;
   localparam logic [63:0] RES = 64'h0000_0000_3f80_0000;
   localparam logic [63:0] DEF = 64'h0000_0000_7f80_0000;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] enableMask = 6'h00;
   logic nonTrappingMode = 1'b0;
   logic flushToZeroControl = 1'b0;
   logic instStart = 1'b0;
   logic instLast = 1'b0;
   logic [1:0] elemFormat = FMT_W;
   logic isCompare = 1'b0;
   logic [5:0] exc = 6'h00;
   logic tny = 1'b0;
   logic sub = 1'b0;
   logic isRecipApprox = 1'b0;
   logic isArith = 1'b1;
   logic nanPropagate = 1'b0;
   logic [2:0] sn = 3'h0;
   logic [2:0] qn = 3'h0;
   logic [191:0] ops = '0;
   logic [LANES-1:0] elemValid, tinyResult, destWrite;
   logic [LANES*6-1:0] rawExc;
   logic [LANES*3-1:0] subnormIn, snanIn, qnanIn;
   logic [LANES*64*3-1:0] operands;
   logic [LANES*64-1:0] resultIn, defaultIn, destValue;
   logic [5:0] causeField, flagsField, trapCause;
   logic vecFpException;
   logic [4:0] exceptionCodeField;
   logic [5:0] flg = 6'h00; // expected sticky flags
   int n_checks = 0;
   int n_mismatch = 0;
   vfe_datapath_model #(.RES_VAL(RES), .DEF_VAL(DEF)) u_dp (.exc(exc), .tny(tny), .sub(sub),
      .sn(sn), .qn(qn), .ops(ops),
      .elemValid(elemValid), .rawExc(rawExc), .tinyResult(tinyResult), .subnormIn(subnormIn),
      .snanIn(snanIn), .qnanIn(qnanIn), .operands(operands), .resultIn(resultIn),
      .defaultIn(defaultIn));
   vfe_unit u_dut (.mclk(mclk), .srst(srst), .enableMask(enableMask),
      .nonTrappingMode(nonTrappingMode), .flushToZeroControl(flushToZeroControl),
      .causeField(causeField), .flagsField(flagsField), .instStart(instStart),
      .instLast(instLast), .elemFormat(elemFormat), .isCompare(isCompare),
      .isRecipApprox(isRecipApprox), .isArith(isArith), .nanPropagate(nanPropagate),
      .elemValid(elemValid),
      .rawExc(rawExc), .tinyResult(tinyResult), .subnormIn(subnormIn), .snanIn(snanIn),
      .qnanIn(qnanIn), .operands(operands), .resultIn(resultIn), .defaultIn(defaultIn),
      .destValue(destValue), .destWrite(destWrite), .vecFpException(vecFpException),
      .exceptionCodeField(exceptionCodeField), .trapCause(trapCause));
   // clock
   initial
   begin
      forever #20 mclk = ~mclk;
   end
   // verdict and end of run
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // compare seen against expected
   task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one single-group instruction, then check write-back, cause, trap, flags
   task run_ext(input logic [5:0] e, input logic t, s, c, input logic [1:0] f,
      input logic [5:0] m, input logic n, z, w, input logic [63:0] d,
      input logic [5:0] ec, input logic tr, input logic p, a, ra,
      input logic [2:0] sq, qq, input logic [191:0] o);
      @(posedge mclk);
      exc <= e; tny <= t; sub <= s; isCompare <= c; elemFormat <= f;
      enableMask <= m; nonTrappingMode <= n; flushToZeroControl <= z;
      nanPropagate <= p;
      isArith <= a;
      isRecipApprox <= ra;
      sn <= sq;
      qn <= qq;
      ops <= o;
      instStart <= 1'b1; instLast <= 1'b1;
      @(posedge mclk);
      instStart <= 1'b0; instLast <= 1'b0;
      #1;
      chk("destWrite", {63'h0, destWrite[0]}, {63'h0, w});
      if (w)
         chk("destValue", destValue[63:0], d);
      chk("causeField", {58'h0, causeField}, {58'h0, ec});
      chk("vecFpException", {63'h0, vecFpException}, {63'h0, tr});
      if (tr)
         chk("trapCause", {58'h0, trapCause}, {58'h0, ec});
      else
         flg = flg | ec;
      chk("flagsField", {58'h0, flagsField}, {58'h0, flg});
   endtask
   // plain arithmetic instruction without nan operands
   task run(input logic [5:0] e, input logic t, s, c, input logic [1:0] f,
      input logic [5:0] m, input logic n, z, w, input logic [63:0] d,
      input logic [5:0] ec, input logic tr);
      run_ext(e, t, s, c, f, m, n, z, w, d, ec, tr, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0, 192'h0);
   endtask
   // watchdog
   initial
   begin
      #(40*400);
      n_mismatch++;
      report_and_stop();
   end
   // test sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      run(EXC_O, 0, 0, 0, FMT_W, 6'h00, 0, 0, 1, DEF, 6'h05, 0);
      run(6'h00, 0, 0, 0, FMT_W, 6'h00, 0, 0, 1, RES, 6'h00, 0);
      run(EXC_U, 0, 0, 0, FMT_W, 6'h00, 0, 0, 1, RES, 6'h00, 0);
      run(EXC_O, 0, 0, 0, FMT_W, EXC_O, 0, 0, 0, RES, 6'h04, 1);
      run(EXC_E, 0, 0, 0, FMT_W, 6'h00, 0, 0, 0, RES, 6'h20, 1);
      run(EXC_E, 0, 0, 0, FMT_W, 6'h00, 1, 0, 1, SNAN_W | 64'h20, 6'h00, 0);
      run(EXC_V | EXC_Z, 0, 0, 0, FMT_W, EXC_V, 1, 0, 1, SNAN_W | 64'h18, 6'h00, 0);
      run(6'h00, 1, 0, 0, FMT_W, 6'h00, 0, 1, 1, 64'h0, 6'h03, 0);
      run(6'h00, 1, 0, 0, FMT_W, 6'h00, 0, 0, 0, RES, 6'h20, 1);
      run(6'h00, 1, 0, 0, FMT_H, 6'h00, 0, 1, 0, RES, 6'h20, 1);
      run(6'h00, 0, 1, 1, FMT_W, 6'h00, 0, 1, 1, RES, 6'h00, 0);
      run(6'h00, 0, 1, 0, FMT_D, 6'h00, 0, 1, 1, DEF, 6'h01, 0);
      run_ext(6'h00, 0, 0, 0, FMT_W, 6'h00, 0, 0, 1, 64'h7fc0_1234, 6'h00, 0,
         1, 1, 0, 3'h0, 3'h2, {64'h0, 64'h7fc0_1234, 64'h0});
      run_ext(6'h00, 0, 0, 0, FMT_W, 6'h00, 0, 0, 1, 64'hffc0_0005,
         6'h10, 0, 1, 1, 0, 3'h5, 3'h2, {64'h7f80_0077, 64'h7fc0_0abc, 64'hff80_0005});
      run_ext(6'h00, 0, 0, 0, FMT_H, 6'h00, 0, 0, 1, 64'h7e01, 6'h10, 0,
         1, 1, 0, 3'h1, 3'h0, {128'h0, 64'h7c01});
      run_ext(6'h00, 1, 0, 0, FMT_W, 6'h00, 0, 1, 1, 64'h0, 6'h00, 0,
         0, 1, 1, 3'h0, 3'h0, 192'h0);
      run_ext(6'h00, 1, 0, 0, FMT_W, 6'h00, 0, 1, 0, RES, 6'h20, 1,
         0, 0, 0, 3'h0, 3'h0, 192'h0);
      report_and_stop();
   end
endmodule // test_vfe_unit
